//--- rsc_pkg.sv
package rsc_pkg;

  // ==========================================================
  // bus geometry and register map
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [APB_AW-1:0] OFS_THRESH = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CAUSE = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h08;
  localparam logic [APB_AW-1:0] OFS_IRQ_ST = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_IRQ_MSK = 8'h10;

  // ==========================================================
  // threshold select codes
  localparam logic [7:0] THR_RESET = 8'h55;
  localparam logic [7:0] THR_2V10 = 8'h55;
  localparam logic [7:0] THR_2V55 = 8'h33;
  localparam logic [7:0] THR_3V15 = 8'h99;
  localparam logic [7:0] THR_3V80 = 8'haa;

  // watchdog enable field codes
  localparam logic [4:0] WDOG_DIS = 5'h15;
  localparam logic [4:0] WDOG_EN = 5'h0a;

  // ==========================================================
  // field positions
  localparam int CAUSE_WCODE = 0;
  localparam int CAUSE_THR = 1;
  localparam int CAUSE_UV = 2;
  localparam int CAUSE_KEEP = 7;
  localparam int STAT_TO = 0;
  localparam int STAT_PDF = 1;
  localparam int IRQ_W = 4;
  localparam int IRQ_UV = 0;
  localparam int IRQ_THR = 1;
  localparam int IRQ_WCODE = 2;
  localparam int IRQ_WTO = 3;

  // ==========================================================
  // timing
  localparam longint CLK_KHZ = 40000;
  localparam longint POR_HOLD_US = 50000;
  localparam longint WTO_HOLD_US = 16700;
  localparam longint UV_QUAL_US = 100;
  localparam int HOLD_W = 22;
  localparam int QUAL_W = 13;
  localparam int POR_HOLD_CYC = int'(POR_HOLD_US * CLK_KHZ / 1000);
  localparam int WTO_HOLD_CYC = int'(WTO_HOLD_US * CLK_KHZ / 1000);
  localparam int UV_QUAL_CYC = int'((UV_QUAL_US * CLK_KHZ + 999) / 1000);
  localparam logic [1:0] LIRC_LAST = 2'h1;

  // boot values handed to the core
  localparam int PC_W = 13;
  localparam int PORT_W = 8;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'hff;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b11
  } rsc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } rsc_apb_req_t;

  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } rsc_apb_rsp_t;

  typedef struct packed {
    logic core_n;
    logic periph_n;
    logic regs_n;
  } rsc_rst_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PORT_W-1:0] portData;
    logic [PORT_W-1:0] portDir;
  } rsc_boot_t;

endpackage

//--- rsc_reset_controller.sv
`timescale 1ns/1ps

module rsc_reset_controller #(
  parameter int POR_HOLD = rsc_pkg::POR_HOLD_CYC,
  parameter int WTO_HOLD = rsc_pkg::WTO_HOLD_CYC,
  parameter int UV_QUAL = rsc_pkg::UV_QUAL_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire rsc_pkg::rsc_apb_req_t apbReq,
  output rsc_pkg::rsc_apb_rsp_t apbRsp,
  input wire logic lowSupplyAsync,
  input wire logic lowSpeedRcClock,
  input wire logic [4:0] watchdogEnableCode,
  input wire logic watchdogTimeout,
  input wire logic powerDown,
  input wire logic haltEntry,
  output logic [7:0] thresholdCode,
  output logic idleSysclkKeep,
  output rsc_pkg::rsc_rst_t rstNets,
  output rsc_pkg::rsc_boot_t bootVals,
  output logic irq
);
  import rsc_pkg::*;

  // ==========================================================
  // synchronisers
  logic lsMeta_r;
  logic lsSync_r;
  logic lcMeta_r;
  logic lcSync_r;
  logic lcLast_r;
  wire lircEdge = lcSync_r & ~lcLast_r;

  // two stages for supply comparator and slow clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lsMeta_r <= 1'b0;
      lsSync_r <= 1'b0;
      lcMeta_r <= 1'b0;
      lcSync_r <= 1'b0;
      lcLast_r <= 1'b0;
    end else begin
      lsMeta_r <= lowSupplyAsync;
      lsSync_r <= lsMeta_r;
      lcMeta_r <= lowSpeedRcClock;
      lcSync_r <= lcMeta_r;
      lcLast_r <= lcSync_r;
    end
  end

  // ==========================================================
  // source qualification
  logic [QUAL_W-1:0] qualCnt_r;
  logic [QUAL_W-1:0] qualCnt_nxt;
  logic [7:0] thr_r;
  logic [7:0] thr_nxt;
  wire uvEnable = ~powerDown;
  wire uvLow = lsSync_r & uvEnable;
  wire qualDone = (qualCnt_r == QUAL_W'(UV_QUAL));
  wire uvValid = uvLow & qualDone;
  wire thrOk = (thr_r == THR_2V10) | (thr_r == THR_2V55) |
               (thr_r == THR_3V15) | (thr_r == THR_3V80);
  wire thrBad = ~thrOk;
  wire wcBad = (watchdogEnableCode != WDOG_EN) &
               (watchdogEnableCode != WDOG_DIS);

  // short dips clear the count and never reach the reset
  assign qualCnt_nxt = !uvLow ? '0 :
                       qualDone ? qualCnt_r :
                       qualCnt_r + QUAL_W'(1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qualCnt_r <= '0;
    end else begin
      qualCnt_r <= qualCnt_nxt;
    end
  end

  // ==========================================================
  // sequencer
  rsc_state_t state_r;
  rsc_state_t state_nxt;
  logic [1:0] lircCnt_r;
  logic [1:0] lircCnt_nxt;
  logic [2:0] pend_r;
  logic [2:0] pend_nxt;
  logic [HOLD_W-1:0] hold_r;
  logic [HOLD_W-1:0] hold_nxt;
  wire [2:0] pendAll = pend_r | {wcBad, thrBad, uvValid};
  wire fireLvr = (state_r == ST_WAIT) & lircEdge &
                 (lircCnt_r == LIRC_LAST);
  wire fireWto = (state_r != ST_HOLD) & watchdogTimeout;
  wire setUv = fireLvr & pendAll[0];
  wire setThr = fireLvr & pendAll[1];
  wire setWc = fireLvr & pendAll[2];

  // merged request with slow-clock delay and hold timer
  always_comb begin
    state_nxt = state_r;
    lircCnt_nxt = lircCnt_r;
    pend_nxt = pend_r;
    hold_nxt = hold_r;
    unique case (state_r)
      ST_RUN: begin
        if (fireWto) begin
          state_nxt = ST_HOLD;
          hold_nxt = HOLD_W'(WTO_HOLD);
        end else if (|pendAll) begin
          state_nxt = ST_WAIT;
          lircCnt_nxt = 2'h0;
          pend_nxt = pendAll;
        end
      end
      ST_WAIT: begin
        pend_nxt = pendAll;
        if (lircEdge) begin
          lircCnt_nxt = lircCnt_r + 2'h1;
        end
        if (fireWto) begin
          state_nxt = ST_HOLD;
          hold_nxt = HOLD_W'(WTO_HOLD);
        end else if (fireLvr) begin
          state_nxt = ST_HOLD;
          hold_nxt = HOLD_W'(POR_HOLD);
          pend_nxt = 3'h0;
        end
      end
      ST_HOLD: begin
        if (uvValid) begin
          hold_nxt = HOLD_W'(POR_HOLD);
        end else if (hold_r <= HOLD_W'(1)) begin
          state_nxt = ST_RUN;
          hold_nxt = '0;
        end else begin
          hold_nxt = hold_r - HOLD_W'(1);
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        hold_nxt = HOLD_W'(POR_HOLD);
      end
    endcase
  end

  // power-on starts in the long hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_HOLD;
      hold_r <= HOLD_W'(POR_HOLD);
      lircCnt_r <= 2'h0;
      pend_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      lircCnt_r <= lircCnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================
  // reset nets and boot values
  wire holdNxt = (state_nxt == ST_HOLD);

  // registered from the merged request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstNets <= '0;
      bootVals <= '{pc: PC_RESET, portData: PORT_RESET, portDir: PORT_RESET};
    end else begin
      rstNets <= {3{~holdNxt}};
      if (holdNxt) begin
        bootVals.pc <= PC_RESET;
        bootVals.portData <= PORT_RESET;
        bootVals.portDir <= PORT_RESET;
      end
    end
  end

  // ==========================================================
  // apb slave
  wire setup = apbReq.psel & ~apbReq.penable;
  wire access = apbReq.psel & apbReq.penable & apbRsp.pready;
  wire wr = access & apbReq.pwrite;
  wire [APB_AW-1:0] addr = apbReq.paddr;
  wire [7:0] wd = apbReq.pwdata[7:0];
  wire selThr = (addr == OFS_THRESH);
  wire selCause = (addr == OFS_CAUSE);
  wire selStat = (addr == OFS_STAT);
  wire selIst = (addr == OFS_IRQ_ST);
  wire selImsk = (addr == OFS_IRQ_MSK);
  wire mapped = selThr | selCause | selStat | selIst | selImsk;

  // ==========================================================
  // cause, status and interrupt registers
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;
  logic keep_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] ist_nxt;
  logic [IRQ_W-1:0] imsk_r;
  wire [2:0] causeSet = {setUv, setThr, setWc};
  wire [2:0] causeWr = {wd[CAUSE_UV], wd[CAUSE_THR], wd[CAUSE_WCODE]};
  wire [IRQ_W-1:0] evt = {fireWto, setWc, setThr, setUv};

  // hardware set beats a software clear in the same cycle
  assign cause_nxt = causeSet |
                     ((wr & selCause) ? (cause_r & causeWr) : cause_r);
  assign stat_nxt[STAT_TO] = fireWto | (stat_r[STAT_TO] &
                             ~(wr & selStat & wd[STAT_TO]));
  assign stat_nxt[STAT_PDF] = haltEntry | (stat_r[STAT_PDF] &
                              ~(wr & selStat & wd[STAT_PDF]));
  assign ist_nxt = evt | (ist_r & ~((wr & selIst) ? wd[IRQ_W-1:0] : '0));
  assign thr_nxt = setThr ? THR_RESET :
                   (wr & selThr) ? wd : thr_r;

  // flags survive the internal reset; only power-on and software writes clear them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 3'h0;
      keep_r <= 1'b0;
      stat_r <= 2'h0;
      ist_r <= '0;
      imsk_r <= '0;
      thr_r <= THR_RESET;
    end else begin
      cause_r <= cause_nxt;
      stat_r <= stat_nxt;
      ist_r <= ist_nxt;
      thr_r <= thr_nxt;
      if (wr & selCause) begin
        keep_r <= wd[CAUSE_KEEP];
      end
      if (wr & selImsk) begin
        imsk_r <= wd[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // read mux and response
  wire [7:0] causeRd = {keep_r, 4'h0, cause_r};
  wire [7:0] rdByte = selThr ? thr_r :
                      selCause ? causeRd :
                      selStat ? {6'h00, stat_r} :
                      selIst ? {4'h0, ist_r} :
                      selImsk ? {4'h0, imsk_r} : 8'h00;

  // no wait state: pready and data registered in setup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= setup;
      apbRsp.pslverr <= setup & ~mapped;
      apbRsp.prdata <= setup ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  // ==========================================================
  // outputs to analog, core and cpu
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thresholdCode <= THR_RESET;
      idleSysclkKeep <= 1'b0;
      irq <= 1'b0;
    end else begin
      thresholdCode <= thr_nxt;
      idleSysclkKeep <= (wr & selCause) ? wd[CAUSE_KEEP] : keep_r;
      irq <= |(ist_nxt & imsk_r);
    end
  end

endmodule // rsc_reset_controller

//--- rsc_reset_monitor.sv
`timescale 1ns/1ps

// ==========================================================
// port checker for the reset controller
module rsc_reset_monitor #(
  parameter int POR_HOLD = 50,
  parameter int WTO_HOLD = 30
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire rsc_pkg::rsc_apb_req_t apbReq,
  input wire rsc_pkg::rsc_apb_rsp_t apbRsp,
  input wire logic watchdogTimeout,
  input wire logic [7:0] thresholdCode,
  input wire rsc_pkg::rsc_rst_t rstNets,
  input wire rsc_pkg::rsc_boot_t bootVals
);
  import rsc_pkg::*;
  logic [7:0] lowCnt;
  wire thrOk = thresholdCode inside {THR_2V10, THR_2V55, THR_3V15, THR_3V80};

  // cycles spent in internal reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) lowCnt <= 8'h00;
    else if (rstNets.core_n) lowCnt <= 8'h00;
    else lowCnt <= lowCnt + 8'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence causeRead;
    apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == OFS_CAUSE && apbRsp.pready;
  endsequence
  sequence netsFall;
    $fell(rstNets.core_n);
  endsequence

  chk_boot_pc: assert property (bootVals.pc == PC_RESET)
    else $error("program counter boot value wrong");
  chk_boot_ports: assert property (bootVals.portData == PORT_RESET && bootVals.portDir == PORT_RESET)
    else $error("port boot values wrong");
  chk_nets_merged: assert property (rstNets.core_n == rstNets.periph_n && rstNets.core_n == rstNets.regs_n)
    else $error("reset nets differ");
  chk_cause_pad: assert property (causeRead |-> apbRsp.prdata[6:3] == 4'h0)
    else $error("cause padding bits not zero");
  chk_code_fault: assert property (!thrOk && rstNets.core_n |-> ##[1:80] !rstNets.core_n)
    else $error("invalid threshold code gave no reset");
  chk_code_reload: assert property (netsFall ##0 !$past(thrOk) |-> ##[0:2] thresholdCode == THR_RESET)
    else $error("threshold not reloaded");
  chk_thr_kept: assert property (netsFall ##0 $past(thrOk) |-> thresholdCode == $past(thresholdCode))
    else $error("threshold changed by reset");
  chk_hold_span: assert property ($rose(rstNets.core_n) |-> lowCnt >= WTO_HOLD - 1 && lowCnt <= POR_HOLD + 2)
    else $error("reset hold length wrong");
  chk_wdog_reset: assert property (watchdogTimeout && rstNets.core_n && thrOk |-> ##[1:2] !rstNets.core_n)
    else $error("time-out gave no reset");
endmodule // rsc_reset_monitor

bind rsc_reset_controller rsc_reset_monitor #(.POR_HOLD(POR_HOLD), .WTO_HOLD(WTO_HOLD))
  rsc_reset_monitor_inst (.clk, .arst_n, .apbReq, .apbRsp, .watchdogTimeout, .thresholdCode,
  .rstNets, .bootVals);

//--- rsc_tb.sv
`timescale 1ns/1ps

// ==========================================================
// reset controller testbench
module testbench;
  import rsc_pkg::*;
  localparam int POR_H = 50;
  localparam int WTO_H = 30;
  localparam logic [7:0] CODES [4] = '{THR_2V10, THR_2V55, THR_3V15, THR_3V80};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  rsc_apb_req_t req = '0;
  rsc_apb_rsp_t rsp;
  logic lowSup = 1'b0;
  logic rcClk = 1'b0;
  logic [3:0] rcDiv = 4'h0;
  logic [4:0] wdCode = WDOG_EN;
  logic wdTo = 1'b0;
  logic pwrDn = 1'b0;
  logic halt = 1'b0;
  logic [7:0] thr;
  logic keep;
  rsc_rst_t nets;
  rsc_boot_t boot;
  logic irq;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int n_compared = 0;
  int cnt;

  rsc_reset_controller #(.POR_HOLD(POR_H), .WTO_HOLD(WTO_H), .UV_QUAL(8)) rsc_reset_controller_inst (
    .clk(clk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp), .lowSupplyAsync(lowSup),
    .lowSpeedRcClock(rcClk), .watchdogEnableCode(wdCode), .watchdogTimeout(wdTo),
    .powerDown(pwrDn), .haltEntry(halt), .thresholdCode(thr), .idleSysclkKeep(keep),
    .rstNets(nets), .bootVals(boot), .irq(irq));

  // system clock and slow clock of 16 cycles
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    rcDiv <= rcDiv + 4'h1;
    rcClk <= rcDiv[3];
  end

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, idle cycle after it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      errors++;
      test_done();
    end
    @(negedge clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic waitNets(input logic lvl, input int lim);
    cnt = 0;
    while (nets.core_n !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        errors++;
        test_done();
      end
    end
  endtask

  // internal reset pulse of a given hold
  task automatic hit(input int hold);
    waitNets(1'b0, 100);
    waitNets(1'b1, 200);
    check(32'(cnt >= hold - 1 && cnt <= hold + 2), 32'h1, "hold");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    waitNets(1'b1, 200);
    check(32'(boot), 32'({PC_RESET, PORT_RESET, PORT_RESET}), "boot");
    rdChk(OFS_THRESH, 32'h55, "thrPor");
    rdChk(OFS_CAUSE, 32'h0, "causePor");
    foreach (CODES[k]) begin
      apb(1'b1, OFS_THRESH, 32'(CODES[k]));
      rdChk(OFS_THRESH, 32'(CODES[k]), "code");
    end
    repeat (80) @(posedge clk);
    check(32'(nets.core_n), 32'h1, "validCodes");
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0, "unmappedRd");
    check(32'(err), 32'h1, "unmappedErr");
    @(posedge clk) lowSup <= 1'b1;
    repeat (4) @(posedge clk);
    lowSup <= 1'b0;
    repeat (100) @(posedge clk);
    check(32'(nets.core_n), 32'h1, "dip");
    apb(1'b1, OFS_THRESH, 32'h33);
    @(posedge clk) lowSup <= 1'b1;
    repeat (20) @(posedge clk);
    lowSup <= 1'b0;
    hit(POR_H);
    rdChk(OFS_THRESH, 32'h33, "uvThr");
    rdChk(OFS_CAUSE, 32'h04, "uvCause");
    apb(1'b1, OFS_CAUSE, 32'h84);
    check(32'(keep), 32'h1, "keep");
    rdChk(OFS_CAUSE, 32'h84, "keepFlag");
    apb(1'b1, OFS_CAUSE, 32'h0);
    rdChk(OFS_CAUSE, 32'h0, "clrFlag");
    apb(1'b1, OFS_THRESH, 32'h00);
    hit(POR_H);
    rdChk(OFS_THRESH, 32'h55, "thrReload");
    rdChk(OFS_CAUSE, 32'h02, "thrCause");
    @(posedge clk) wdCode <= 5'h03;
    waitNets(1'b0, 100);
    @(posedge clk) wdCode <= WDOG_EN;
    waitNets(1'b1, 200);
    rdChk(OFS_CAUSE, 32'h03, "wdCause");
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    @(posedge clk) wdTo <= 1'b1;
    @(posedge clk) wdTo <= 1'b0;
    hit(WTO_H);
    rdChk(OFS_STAT, 32'h3, "stat");
    apb(1'b1, OFS_STAT, 32'h3);
    rdChk(OFS_STAT, 32'h0, "statClr");
    @(posedge clk) pwrDn <= 1'b1;
    lowSup <= 1'b1;
    repeat (100) @(posedge clk);
    check(32'(nets.core_n), 32'h1, "powerDown");
    lowSup <= 1'b0;
    pwrDn <= 1'b0;
    apb(1'b1, OFS_IRQ_MSK, 32'h0);
    check(32'(irq), 32'h0, "irqMasked");
    apb(1'b1, OFS_IRQ_MSK, 32'h9);
    @(negedge clk);
    check(32'(irq), 32'h1, "irqOn");
    rdChk(OFS_IRQ_ST, 32'hf, "irqSt");
    apb(1'b1, OFS_IRQ_ST, 32'hf);
    check(32'(irq), 32'h0, "irqClr");
    test_done();
  end
endmodule // testbench
